// file: hdl/amlc_alert_ctrl.v
// Alert mask, latch and pin control with an AHB-Lite register slave
// Assumes single word transfers from one master; event inputs are synchronous to hclk
`timescale 1ns/100ps
`include "amlc_regs.vh"

// Notes on behaviour
// - Polarity bit clear drives pin active low, set drives it active high.
// - Mode zero holds pin asserted while an unmasked latched event remains; one reserved.
// - Mode two pulses pin 2 ms in every 4 ms while unmasked latched event persists.
// - Mode three gives one 2 ms pulse per cycle with an unmasked event; events are ignored until the last cycle of its 4 ms period.
// - Readback bit clear shows all latched events; set shows only unmasked ones.
// - Mask bit 7 suppresses the serial port clock error; register resets to ones.
// - Mask bit 6 suppresses the PLL lock event; resets to one.
// - Latch bit 7 sets on serial port clock error; read-only, self-clearing, resets zero.
// - Latch bit 6 sets on PLL lock event; read-only and self-clearing.
// - Config, mask and latch decode at indices 0x32, 0x33, 0x36 of page zero.
// - Mask resets to FFh, low six reserved bits read-write with reset 3Fh.
module amlc_alert_ctrl #(
	parameter PULSE_CYC  = `AMLC_PULSE_CYC,
	parameter PERIOD_CYC = `AMLC_PERIOD_CYC
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        audio_serial_port_clk_err,
	input  wire        pll_lock_event,
	output reg         alert_out,
	output wire        alert_active
);

	////////////////////////////////////////////////////////////////
	// Address decode helpers
	function [9:0] amlc_addr;
		input [7:0] idx;
		begin
			amlc_addr = {idx, 2'b00};
		end
	endfunction

	function amlc_hit;
		input [31:0] a;
		input [7:0]  idx;
		begin
			amlc_hit = (a[31:10] == 22'h000000) && (a[9:0] == amlc_addr(idx));
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus address phase capture
	reg        wr_pend_q;
	reg        rd_pend_q;
	reg [31:0] addr_q;
	reg [7:0]  cfg_q;
	reg [7:0]  mask_q;
	reg [7:0]  latch_q;

	wire phase_ok = hsel && hready && htrans[1];
	wire rd_latch = phase_ok && !hwrite && amlc_hit(haddr, `AMLC_IDX_LATCH);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 32'h00000000;
		end else begin
			wr_pend_q <= phase_ok && hwrite;
			rd_pend_q <= phase_ok && !hwrite;
			if (phase_ok) begin
				addr_q <= haddr;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Writable registers
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q  <= `AMLC_CFG_RESET;
			mask_q <= `AMLC_MASK_RESET;
		end else if (wr_pend_q) begin
			if (amlc_hit(addr_q, `AMLC_IDX_CONFIG)) begin
				cfg_q <= hwdata[7:0] & `AMLC_CFG_WMASK;
			end
			if (amlc_hit(addr_q, `AMLC_IDX_MASK)) begin
				mask_q <= hwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Event latching
	reg  [7:0] ev_c;
	wire [7:0] unmasked_ev_c = ev_c & ~mask_q;

	always @* begin
		ev_c = 8'h00;
		ev_c[`AMLC_SRC_ASP_BIT] = audio_serial_port_clk_err;
		ev_c[`AMLC_SRC_PLL_BIT] = pll_lock_event;
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			latch_q <= `AMLC_LATCH_RESET;
		end else if (rd_latch) begin
			latch_q <= ev_c;
		end else begin
			latch_q <= latch_q | ev_c;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read data
	wire [7:0] latch_view = cfg_q[`AMLC_CFG_RDSEL_BIT] ? (latch_q & ~mask_q) : latch_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_latch) begin
			hrdata <= {24'h000000, latch_view & `AMLC_LATCH_RMASK};
		end else if (phase_ok && !hwrite && amlc_hit(haddr, `AMLC_IDX_CONFIG)) begin
			hrdata <= {24'h000000, cfg_q};
		end else if (phase_ok && !hwrite && amlc_hit(haddr, `AMLC_IDX_MASK)) begin
			hrdata <= {24'h000000, mask_q};
		end else if (phase_ok) begin
			hrdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////
	// Alert generation
	wire [1:0] mode       = cfg_q[`AMLC_CFG_MODE_HI:`AMLC_CFG_MODE_LO];
	wire       pending    = |(latch_q & ~mask_q & `AMLC_LATCH_RMASK);
	wire       new_ev     = |(unmasked_ev_c & `AMLC_LATCH_RMASK);
	wire       pulse_act;
	reg        assert_c;

	amlc_pulse_timer #(
		.PULSE_CYC  (PULSE_CYC),
		.PERIOD_CYC (PERIOD_CYC),
		.CW         (16)
	) u_timer (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.start     ((mode == `AMLC_MODE_REPEAT) ? pending : (mode == `AMLC_MODE_ONCE) && new_ev),
		.repeat_en (mode == `AMLC_MODE_REPEAT),
		.run       (pending),
		.active_q  (pulse_act)
	);

	always @* begin
		case (mode)
			`AMLC_MODE_LEVEL: begin
				assert_c = pending;
			end
			`AMLC_MODE_REPEAT: begin
				assert_c = pulse_act;
			end
			`AMLC_MODE_ONCE: begin
				assert_c = pulse_act;
			end
			default: begin
				assert_c = 1'b0;
			end
		endcase
	end

	assign alert_active = assert_c;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alert_out <= 1'b1;
		end else begin
			alert_out <= cfg_q[`AMLC_CFG_POL_BIT] ? assert_c : !assert_c;
		end
	end

endmodule

// file: hdl/amlc_regs.vh
// Register offsets, field positions, reset values and timing counts of the alert block
// Assumes inclusion by bare name from the design files
`ifndef AMLC_REGS_VH
`define AMLC_REGS_VH

// Page 0x00 offsets; printed offsets are not all multiples of four, so byte address is four times index
`define AMLC_PAGE             8'h00
`define AMLC_IDX_CONFIG       8'h32
`define AMLC_IDX_MASK         8'h33
`define AMLC_IDX_LATCH        8'h36

// Config fields
`define AMLC_CFG_POL_BIT      7
`define AMLC_CFG_MODE_HI      6
`define AMLC_CFG_MODE_LO      5
`define AMLC_CFG_RDSEL_BIT    2
`define AMLC_CFG_WMASK        8'he4
`define AMLC_CFG_RESET        8'h00

// Mask and latch fields
`define AMLC_SRC_ASP_BIT      7
`define AMLC_SRC_PLL_BIT      6
`define AMLC_MASK_RESET       8'hff
`define AMLC_LATCH_RESET      8'h00
`define AMLC_LATCH_RMASK      8'hc0

// Event modes
`define AMLC_MODE_LEVEL       2'h0
`define AMLC_MODE_RSVD        2'h1
`define AMLC_MODE_REPEAT      2'h2
`define AMLC_MODE_ONCE        2'h3

// Timing: pulse 2 ms in every 4 ms at 10 MHz
`define AMLC_CLK_HZ           10000000
`define AMLC_PULSE_US         2000
`define AMLC_PERIOD_US        4000
`define AMLC_PULSE_CYC        ((`AMLC_CLK_HZ / 1000000) * `AMLC_PULSE_US)
`define AMLC_PERIOD_CYC       ((`AMLC_CLK_HZ / 1000000) * `AMLC_PERIOD_US)

`endif

// file: hdl/amlc_pulse_timer.v
// Pulse timer for the alert pin: one-shot or repeating high/low pattern
// Assumes start is a one-cycle pulse on hclk and run a level on hclk
`timescale 1ns/100ps
`include "amlc_regs.vh"

module amlc_pulse_timer #(
	parameter PULSE_CYC  = `AMLC_PULSE_CYC,
	parameter PERIOD_CYC = `AMLC_PERIOD_CYC,
	parameter CW         = 16
) (
	input  wire hclk,
	input  wire hresetn,
	input  wire start,
	input  wire repeat_en,
	input  wire run,
	output reg  active_q
);

	reg  [CW-1:0] cnt_q;
	reg           busy_q;
	wire [CW-1:0] last_c  = PERIOD_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
	wire [CW-1:0] pulse_c = PULSE_CYC[CW-1:0];

	////////////////////////////////////////////////////////////////
	// Counter: busy runs a full period unless run drops in repeat mode; pin active in first half
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q    <= {CW{1'b0}};
			busy_q   <= 1'b0;
			active_q <= 1'b0;
		end else if (!busy_q) begin
			cnt_q    <= {CW{1'b0}};
			busy_q   <= start;
			active_q <= start;
		end else if (repeat_en ? !run : 1'b0) begin
			busy_q   <= 1'b0;
			active_q <= 1'b0;
			cnt_q    <= {CW{1'b0}};
		end else if (cnt_q == last_c) begin
			cnt_q    <= {CW{1'b0}};
			busy_q   <= repeat_en ? run : start;
			active_q <= repeat_en ? run : start;
		end else begin
			cnt_q    <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
			active_q <= (cnt_q + {{(CW-1){1'b0}}, 1'b1}) < pulse_c;
		end
	end

endmodule

// file: tb/amlc_alert_properties.sv
// Port checker for the alert block
// Assumes bind to amlc_alert_ctrl run with PULSE_CYC 4, PERIOD_CYC 8
`timescale 1ns/100ps
module amlc_alert_properties #(
	parameter PULSE_CYC  = 4,
	parameter PERIOD_CYC = 8
) (
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic        hready,
	input logic [31:0] hwdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic [31:0] hrdata,
	input logic        audio_serial_port_clk_err,
	input logic        pll_lock_event,
	input logic        alert_out,
	input logic        alert_active
);
	logic        wv_q;
	logic [31:0] wa_q;
	logic [7:0]  cfg_q;
	logic [7:0]  msk_q;
	wire  [1:0]  md = cfg_q[6:5];
	// Shadow of config and mask writes
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wv_q  <= 1'b0;
			wa_q  <= 32'h0;
			cfg_q <= 8'h00;
			msk_q <= 8'hff;
		end else begin
			wv_q <= hsel && hready && htrans[1] && hwrite;
			wa_q <= haddr;
			if (wv_q && wa_q == 32'hc8)
				cfg_q <= hwdata[7:0];
			if (wv_q && wa_q == 32'hcc)
				msk_q <= hwdata[7:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_hi; hrdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_rdy; hreadyout && !hresp; endproperty
	a_rdy: assert property (p_rdy) else $error("wait or error response");
	property p_pol; alert_out == ($past(cfg_q[7]) ? $past(alert_active) : !$past(alert_active)); endproperty
	a_pol: assert property (p_pol) else $error("pin sense wrong");
	property p_once; $rose(alert_active) && md == 2'h3 |-> alert_active[*4] ##1 !alert_active; endproperty
	a_once: assert property (p_once) else $error("single pulse length wrong");
	property p_rep; $fell(alert_active) && md == 2'h2 |-> !alert_active[*4]; endproperty
	a_rep: assert property (p_rep) else $error("repeat low phase short");
	property p_msk; md == 2'h0 && msk_q[7:6] == 2'b11 |-> !alert_active; endproperty
	a_msk: assert property (p_msk) else $error("masked source alerts");
	property p_asp; md == 2'h0 && !msk_q[7] && audio_serial_port_clk_err && !wv_q |=> alert_active; endproperty
	a_asp: assert property (p_asp) else $error("clock error not alerting");
	property p_pll; md == 2'h0 && !msk_q[6] && pll_lock_event && !wv_q |=> alert_active; endproperty
	a_pll: assert property (p_pll) else $error("lock event not alerting");
endmodule
bind amlc_alert_ctrl amlc_alert_properties #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_props (.*);

// file: tb/amlc_host_mon.sv
// Host side model: counts alert assertions seen on the pin
// Assumes pol follows the polarity the host programmed
`timescale 1ns/100ps
module amlc_host_mon (
	input  logic hclk,
	input  logic pol,
	input  logic alert_out,
	output int   n_pulse
);
	logic seen_q = 1'b0;
	initial n_pulse = 0;
	always @(posedge hclk) begin
		if ((alert_out ~^ pol) && !seen_q)
			n_pulse <= n_pulse + 1;
		seen_q <= alert_out ~^ pol;
	end
endmodule

// file: tb/amlc_alert_ctrl_tb_top.sv
// Self-checking bench for the alert block
// Assumes short pulse timing: 4 of every 8 cycles
`timescale 1ns/100ps
module amlc_alert_ctrl_tb_top;
	logic        hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, err = 0, pll = 0, pol = 0;
	logic [1:0]  htrans = 0, m;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [7:0]  v;
	logic        hreadyout, hresp, alert_out, alert_active;
	int          n_errors = 0, n_tests = 0, cyc = 0, n_pulse, base;
	always #50 hclk = ~hclk;
	amlc_alert_ctrl #(.PULSE_CYC(4), .PERIOD_CYC(8)) u_amlc_alert_ctrl (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .audio_serial_port_clk_err(err),
		.pll_lock_event(pll), .alert_out(alert_out), .alert_active(alert_active));
	amlc_host_mon u_amlc_host_mon (.hclk(hclk), .pol(pol), .alert_out(alert_out), .n_pulse(n_pulse));
	task automatic chk(input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, d);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= a;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic ev(input logic a, b);
		@(posedge hclk);
		err <= a;
		pll <= b;
		@(posedge hclk);
		err <= 1'b0;
		pll <= 1'b0;
	endtask
	function automatic int exp_pulses(input logic [1:0] md);
		return (md == 2'h2) ? 3 : 1;
	endfunction
	task report_and_stop;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop;
		end
	end
	initial begin
		void'($urandom(90));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1, 32'h400, 32'hff);
		bus(0, 32'hc8, 0);
		chk(r, 0);
		bus(0, 32'hcc, 0);
		chk(r, 8'hff);
		bus(0, 32'hd8, 0);
		chk(r, 0);
		bus(0, 32'h400, 0);
		chk(r, 0);
		v = $urandom;
		bus(1, 32'hcc, v);
		bus(0, 32'hcc, 0);
		chk(r, v);
		v = $urandom;
		v[5] = v[5] & v[6];
		bus(1, 32'hc8, v);
		bus(0, 32'hc8, 0);
		chk(r, v & 8'he4);
		bus(1, 32'hcc, 32'h7f);
		bus(1, 32'hc8, 0);
		ev(1, 1);
		bus(0, 32'hd8, 0);
		chk(r, 8'hc0);
		bus(0, 32'hd8, 0);
		chk(r, 0);
		bus(1, 32'hc8, 32'h04);
		ev(1, 1);
		bus(0, 32'hd8, 0);
		chk(r, 8'h80);
		bus(1, 32'hcc, 32'h3f);
		for (int k = 0; k < 6; k++) begin
			m = 2'((k % 3) ? (k % 3 + 1) : 0);
			pol = (k > 2);
			bus(1, 32'hc8, {pol, m, 5'h0});
			repeat (2) @(posedge hclk);
			base = n_pulse;
			ev($urandom, 1'b1);
			repeat (24) @(posedge hclk);
			chk(n_pulse - base, exp_pulses(m));
			if (m == 2'h0)
				chk(alert_out, pol);
			bus(0, 32'hd8, 0);
			repeat (2) @(posedge hclk);
			chk(alert_out, !pol);
		end
		report_and_stop;
	end
endmodule
